/* src/flpt_top.sv */
// Fan speed control: lookup table, hysteresis, ramp, critical force, tach counter
// Summary of operation
// - Falling temperature compares against setpoints lowered by the hysteresis amount.
// - An active critical-temperature output forces full duty at once, skipping ramp and table.
// - Duty moves one resolution step (1/256 or 1/16) per ramp interval until target.
// - One ramp interval setting applies to all table transitions.
// - The tach counter counts 90 kHz ticks across two fan tach periods, one revolution of a two-pulse fan.
// - The tach count reads as low byte at 0x46 and high byte at 0x47.
// - A beta-compensation enable selects integrated transistor or discrete diode mode.
// - Twelve temperature and duty pairs; at or below the first setpoint (less the hysteresis when falling) the target duty is zero.
// - Setpoint comparison resolution is selectable as 1 degC or 0.5 degC.
`timescale 1ns/1ps
module flpt_top
    import flpt_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire logic [8:0]              i_temp,
    input  wire logic                    i_crit,
    input  wire logic [8*LUT_ENTRIES-1:0] i_lut_temp,
    input  wire logic [8*LUT_ENTRIES-1:0] i_lut_duty,
    input  wire logic [7:0]              i_hyst,
    input  wire logic                    i_half_deg,
    input  wire logic                    i_hires,
    input  wire logic [23:0]             i_ramp_cycles,
    input  wire logic                    i_beta_en,
    input  wire logic                    i_tach,
    input  wire logic [7:0]              i_rd_addr,
    output logic [7:0]                   o_rd_data,
    output logic [7:0]                   o_duty,
    output logic                         o_critical_temp_output,
    output logic                         o_beta_mode
);
    // i_temp: degC in 8.1 fixed point; setpoints in whole degC
    logic        tach_s;
    logic        crit_s;
    logic [8:0]  temp_q;
    logic        falling_q;
    logic        falling_d;
    logic [7:0]  target_d;
    logic [7:0]  duty_q;
    logic [23:0] ramp_cnt_q;
    logic [9:0]  div_q;
    logic        tick_q;
    logic        tach_prev_q;
    logic [15:0] tach_run_q;
    logic [15:0] tach_cnt_q;
    logic [15:0] tach_run_d;
    logic        tach_rise;
    logic        tach_half_q;
    logic [7:0]  step;
    logic [8:0]  cmp_temp;

    // Tach line idles high behind its pull-up
    flpt_sync #(.RST_VAL(1'b1)) u_sync_tach
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    (i_tach),
        .o_q    (tach_s)
    );

    flpt_sync u_sync_crit
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    (i_crit),
        .o_q    (crit_s)
    );

    // Direction tracking
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            temp_q    <= 9'h000;
            falling_q <= 1'b0;
        end
        else
        begin
            temp_q <= i_temp;
            if (i_temp < temp_q)
                falling_q <= 1'b1;
            else if (i_temp > temp_q)
                falling_q <= 1'b0;
        end
    end

    // Direction from the live sample, so the table never uses a stale flag
    assign falling_d = (i_temp < temp_q) ? 1'b1 : (i_temp > temp_q) ? 1'b0 : falling_q;

    // Whole-degree mode drops the half bit before comparing
    assign cmp_temp = i_half_deg ? i_temp : {i_temp[8:1], 1'b0};

    always_comb
    begin
        logic [9:0] sp;
        sp       = 10'h000;
        target_d = 8'h00;
        for (int i = 0; i < LUT_ENTRIES; i++)
        begin
            sp = {1'b0, i_lut_temp[8*i +: 8], 1'b0};
            if (falling_d)
                sp = (sp > {1'b0, i_hyst, 1'b0}) ? sp - {1'b0, i_hyst, 1'b0} : 10'h000;
            // Rising direction uses the setpoint unchanged
            if ({1'b0, cmp_temp} > sp)
                target_d = i_lut_duty[8*i +: 8];
        end
    end

    assign step = i_hires ? STEP_HIRES : STEP_LORES;

    // Ramp: a single interval setting for every transition
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            duty_q     <= 8'h00;
            ramp_cnt_q <= 24'h000000;
        end
        else if (crit_s)
        begin
            duty_q     <= DUTY_FULL;
            ramp_cnt_q <= 24'h000000;
        end
        else if (duty_q == target_d)
            ramp_cnt_q <= 24'h000000;
        else if (ramp_cnt_q >= i_ramp_cycles)
        begin
            ramp_cnt_q <= 24'h000000;
            if (duty_q < target_d)
                duty_q <= (target_d - duty_q < step) ? target_d : duty_q + step;
            else
                duty_q <= (duty_q - target_d < step) ? target_d : duty_q - step;
        end
        else
            ramp_cnt_q <= ramp_cnt_q + 24'h000001;
    end

    // 90 kHz tick from the system clock
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_q  <= 10'h000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == TACH_DIV_LAST);
            div_q  <= (div_q == TACH_DIV_LAST) ? 10'h000 : div_q + 10'h001;
        end
    end

    assign tach_rise  = tach_s && !tach_prev_q;
    // A tick on the capture edge belongs to the closing period, so none is lost
    assign tach_run_d = (tick_q && tach_run_q != TACH_MAX) ? tach_run_q + 16'h0001 : tach_run_q;

    // One revolution of a two-pulse fan spans two rising edges; saturates when stalled
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tach_prev_q <= 1'b1;
            tach_half_q <= 1'b0;
            tach_run_q  <= 16'h0000;
            tach_cnt_q  <= TACH_MAX;
        end
        else
        begin
            tach_prev_q <= tach_s;
            if (tach_rise)
                tach_half_q <= !tach_half_q;
            if (tach_rise && tach_half_q)
            begin
                tach_cnt_q <= tach_run_d;
                tach_run_q <= 16'h0000;
            end
            else
            begin
                tach_run_q <= tach_run_d;
                if (tach_run_d == TACH_MAX)
                    tach_cnt_q <= TACH_MAX;
            end
        end
    end

    // Outputs and register read port
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rd_data              <= 8'h00;
            o_duty                 <= 8'h00;
            o_critical_temp_output <= 1'b0;
            o_beta_mode            <= 1'b0;
        end
        else
        begin
            o_duty                 <= crit_s ? DUTY_FULL : duty_q;
            o_critical_temp_output <= crit_s;
            o_beta_mode            <= i_beta_en;
            unique case (i_rd_addr)
                REG_TACH_LOW:  o_rd_data <= tach_cnt_q[7:0];
                REG_TACH_HIGH: o_rd_data <= tach_cnt_q[15:8];
                default:       o_rd_data <= 8'h00;
            endcase
        end
    end
endmodule

/* src/flpt_pkg.sv */
// Constants shared by the fan lookup-table PWM and tach block
package flpt_pkg;
    localparam int          CLK_HZ          = 50000000;
    localparam int          TACH_CLK_HZ     = 90000;
    localparam int          TACH_DIV        = CLK_HZ / TACH_CLK_HZ;
    localparam logic [9:0]  TACH_DIV_LAST   = 10'(TACH_DIV - 1);
    localparam int          LUT_ENTRIES     = 12;
    localparam logic [7:0]  REG_TACH_LOW    = 8'h46;
    localparam logic [7:0]  REG_TACH_HIGH   = 8'h47;
    localparam logic [7:0]  DUTY_FULL       = 8'hFF;
    localparam logic [7:0]  STEP_HIRES      = 8'h01;
    localparam logic [7:0]  STEP_LORES      = 8'h10;
    localparam logic [15:0] TACH_MAX        = 16'hFFFF;
    localparam logic [7:0]  REG_BETA_EN     = 8'h00;
    localparam int          DIV_HALF_DEG    = 1;
    localparam int          DIV_WHOLE_DEG   = 2;
endpackage

/* src/flpt_sync.sv */
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module flpt_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta_q;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        // Reset to the pin's idle level, so no false edge follows reset
        if (!i_nrst)
        begin
            meta_q <= RST_VAL;
            o_q    <= RST_VAL;
        end
        else
        begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

/* tb/flpt_props.sv */
// Port checker for the fan control block
`timescale 1ns/1ps
module flpt_props
    import flpt_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_crit,
    input  wire logic        i_hires,
    input  wire logic [23:0] i_ramp_cycles,
    input  wire logic        i_beta_en,
    input  wire logic [7:0]  i_rd_addr,
    input  wire logic [7:0]  o_rd_data,
    input  wire logic [7:0]  o_duty,
    input  wire logic        o_critical_temp_output,
    input  wire logic        o_beta_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_crit_full;
        o_critical_temp_output |-> o_duty == DUTY_FULL;
    endproperty
    a_crit_full: assert property (p_crit_full) else $error("duty not full");
    property p_crit_on;
        i_crit [*3] |=> o_critical_temp_output;
    endproperty
    a_crit_on: assert property (p_crit_on) else $error("crit late");
    property p_crit_off;
        !i_crit [*3] |=> !o_critical_temp_output;
    endproperty
    a_crit_off: assert property (p_crit_off) else $error("crit stuck");
    property p_unmapped;
        (i_rd_addr != REG_TACH_LOW && i_rd_addr != REG_TACH_HIGH) |=> o_rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_step;
        (i_hires && $past(i_hires) && !o_critical_temp_output && !$past(o_critical_temp_output))
        |-> (8'(o_duty - $past(o_duty)) <= 8'h01 || 8'($past(o_duty) - o_duty) <= 8'h01);
    endproperty
    a_step: assert property (p_step) else $error("ramp step too big");
    property p_gap;
        ($changed(o_duty) && i_ramp_cycles != 0 && !o_critical_temp_output)
        |=> ($stable(o_duty) || o_critical_temp_output);
    endproperty
    a_gap: assert property (p_gap) else $error("ramp interval short");
    property p_release;
        $fell(o_critical_temp_output) |-> o_duty >= 8'hF0;
    endproperty
    a_release: assert property (p_release) else $error("no ramp from full");
    property p_beta;
        i_beta_en [*2] |=> o_beta_mode;
    endproperty
    a_beta: assert property (p_beta) else $error("beta mode lost");
    c_crit: cover property ($rose(o_critical_temp_output));
    c_high: cover property (i_rd_addr == REG_TACH_HIGH);
    c_step: cover property ($changed(o_duty) && i_hires);
endmodule
bind flpt_top flpt_props u_props (.i_clk, .i_nrst, .i_crit, .i_hires, .i_ramp_cycles,
    .i_beta_en, .i_rd_addr, .o_rd_data, .o_duty, .o_critical_temp_output, .o_beta_mode);

/* tb/flpt_fan.sv */
// Fan model: tach square wave, two pulses a revolution
`timescale 1ns/1ps
module flpt_fan
#(
    parameter int PER = 11100
)
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_duty,
    output logic            o_tach
);
    int cnt = 0;
    // Stopped fan leaves the pulled-up tach line high
    always @(posedge i_clk)
    begin
        cnt <= (i_duty == 8'h00 || cnt == PER - 1) ? 0 : cnt + 1;
        o_tach <= i_duty == 8'h00 || cnt < PER / 2;
    end
endmodule

/* tb/flpt_top_test.sv */
// Self-checking bench for the fan control block
`timescale 1ns/1ps
module flpt_top_test;
    import flpt_pkg::*;
    logic        i_clk = 0, i_nrst = 0, i_crit = 0, i_hires = 0, i_beta_en = 0, i_tach;
    logic        i_half_deg = 0, o_critical_temp_output, o_beta_mode;
    logic [8:0]  i_temp = '0;
    logic [23:0] i_ramp_cycles = 24'h000001;
    logic [7:0]  i_hyst = 8'h03, i_rd_addr = 8'h00, o_rd_data, o_duty, rd;
    logic [95:0] i_lut_temp, i_lut_duty;
    logic [7:0]  lo;
    logic [31:0] rpm;
    int          n_errors = 0, samples_checked = 0;
    flpt_top DUT
    (
        .i_clk                  (i_clk),
        .i_nrst                 (i_nrst),
        .i_temp                 (i_temp),
        .i_crit                 (i_crit),
        .i_lut_temp             (i_lut_temp),
        .i_lut_duty             (i_lut_duty),
        .i_hyst                 (i_hyst),
        .i_half_deg             (i_half_deg),
        .i_hires                (i_hires),
        .i_ramp_cycles          (i_ramp_cycles),
        .i_beta_en              (i_beta_en),
        .i_tach                 (i_tach),
        .i_rd_addr              (i_rd_addr),
        .o_rd_data              (o_rd_data),
        .o_duty                 (o_duty),
        .o_critical_temp_output (o_critical_temp_output),
        .o_beta_mode            (o_beta_mode)
    );
    flpt_fan #(.PER(20 * TACH_DIV)) u_fan (.i_clk, .i_duty(o_duty), .o_tach(i_tach));
    initial forever #10 i_clk = ~i_clk;
    initial
        for (int i = 0; i < 12; i++)
        begin
            i_lut_temp[8*i+:8] = 8'(10 * (i + 1));
            i_lut_duty[8*i+:8] = 8'(16 * (i + 1));
        end
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge i_clk) i_rd_addr <= a;
        @(posedge i_clk) #1 rd = o_rd_data;
    endtask
    // Bounded wait; a hang ends the run
    task automatic wt(input logic [7:0] v);
        int k;
        for (k = 0; k < 1000 && o_duty !== v; k++) @(posedge i_clk) #1;
        chk(v, o_duty);
        if (k == 1000) end_sim;
    endtask
    task automatic st(input logic [7:0] d);
        @(posedge i_clk) i_temp <= {d, 1'b0};
    endtask
    task automatic t_reset;
        rdr(REG_TACH_LOW); chk(8'hFF, rd);
        rdr(REG_TACH_HIGH); chk(8'hFF, rd);
        rdr(8'h48); chk(8'h00, rd);
        wt(8'h00);
        chk(1'b0, o_critical_temp_output);
        chk(1'b0, o_beta_mode);
        $display("Test reset done");
    endtask
    task automatic t_lut;
        st(8'd25); wt(8'h20);
        st(8'd19); repeat (20) @(posedge i_clk); #1 chk(8'h20, o_duty);
        st(8'd16); wt(8'h10);
        st(8'd20); repeat (20) @(posedge i_clk); #1 chk(8'h10, o_duty);
        $display("Test lut done");
    endtask
    task automatic t_crit;
        @(posedge i_clk) {i_hires, i_crit, i_beta_en} <= 3'b111;
        wt(8'hFF);
        chk(1'b1, o_critical_temp_output);
        chk(1'b1, o_beta_mode);
        @(posedge i_clk) i_crit <= 1'b0;
        wt(8'h10);
        chk(1'b0, o_critical_temp_output);
        $display("Test crit done");
    endtask
    // 20.5 degC trips the 20 degC entry only with half-degree compare
    task automatic t_half;
        @(posedge i_clk) i_temp <= 9'h029;
        repeat (20) @(posedge i_clk);
        #1 chk(8'h10, o_duty);
        @(posedge i_clk) i_half_deg <= 1'b1;
        wt(8'h20);
        $display("Test half done");
    endtask
    // Two tach periods of 20 ticks make one revolution
    task automatic t_tach;
        repeat (100 * TACH_DIV) @(posedge i_clk);
        rdr(REG_TACH_LOW);
        lo = rd;
        chk(8'h28, lo);
        rdr(REG_TACH_HIGH);
        chk(8'h00, rd);
        // Host speed from the count, against the model's own revolution time
        rpm = 32'd5400000 / {16'h0000, rd, lo} / 32'd1000;
        chk(16'(60 * (CLK_HZ / 1000) / (2 * 20 * TACH_DIV)), rpm[15:0]);
        $display("Test tach done");
    endtask
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset;
        t_lut;
        t_crit;
        t_half;
        t_tach;
        end_sim;
    end
endmodule
